// >>> shared/dtr_cfg.svh
// Offsets, field positions, reset values and timing counts of the DDR2 command timing block.
// Assumes a 50 MHz system clock and a DDR2 link clock sampled as an ordinary input.
// Behaviour
// - Mode bit 12 picks active power-down exit: fast 2, slow 7 minus latency, or 1 at latency 7.
// - Device applies a termination setting within 12 ns of its mode command; here it lands two system clocks (40 ns) after the command decodes.
// - Device presents the selected calibration drive within 12 ns; here it lands two system clocks (40 ns) after the command decodes.
// - Complement strobe is used only when the strobe-enable bit selects differential.
`ifndef DTR_CFG_SVH
`define DTR_CFG_SVH

`define DTR_CLK_PERIOD_NS   20
`define DTR_MODE_UPD_NS     12
`define DTR_MODE_UPD_CYC    (((`DTR_MODE_UPD_NS / `DTR_CLK_PERIOD_NS) < 1) ? 1 : (`DTR_MODE_UPD_NS / `DTR_CLK_PERIOD_NS))
`define DTR_OCD_OUT_NS      12
`define DTR_OCD_OUT_CYC     (((`DTR_OCD_OUT_NS / `DTR_CLK_PERIOD_NS) < 1) ? 1 : (`DTR_OCD_OUT_NS / `DTR_CLK_PERIOD_NS))

`define DTR_CCD_NCK         2
`define DTR_MRD_NCK         2
`define DTR_CKE_NCK         3
`define DTR_XSRD_NCK        200
`define DTR_XP_NCK          2
`define DTR_XARD_NCK        2
`define DTR_XARDS_BASE_NCK  7

`define DTR_BA_MR           3'h0
`define DTR_BA_EMR1         3'h1
`define DTR_A_PD_EXIT       12
`define DTR_A_DS            1
`define DTR_A_RTT0          2
`define DTR_A_RTT1          6
`define DTR_A_AL_LO         3
`define DTR_A_OCD_LO        7
`define DTR_A_DQS_DIS       10
`define DTR_A_AP            10

`define DTR_OCD_DRV1        3'h1
`define DTR_OCD_DRV0        3'h2

`define DTR_RST_RTT         2'h0
`define DTR_RST_AL          3'h0
`define DTR_RST_DQS_DIFF    1'b1

`endif

// >>> shared/dtr_pkg.sv
// Types of the DDR2 command timing block.
// Assumes nothing beyond a SystemVerilog compiler.
package dtr_pkg;

  typedef enum logic [3:0] {
    PD_RUN    = 4'b0001,
    PD_ACTIVE = 4'b0010,
    PD_PRECH  = 4'b0100,
    PD_SELF   = 4'b1000
  } dtr_pd_t;

  typedef enum logic [1:0] {
    DRV_NORMAL = 2'h0,
    DRV_HIGH   = 2'h1,
    DRV_LOW    = 2'h2
  } dtr_drv_t;

endpackage

// >>> rtl/dtr_core.sv
// DDR2 device-side command timing logic: mode settings, power-down tracking, spacing checks.
// Assumes the link clock, clock enable, command and address pins arrive asynchronously.
`timescale 1ns/1ps
`include "dtr_cfg.svh"

module dtr_core #(
  parameter int ADDR_W = 14,
  parameter int WAIT_W = 8
) (
  // System
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // DDR2 link pins
  input  wire logic                ck_in,
  input  wire logic                cke_in,
  input  wire logic                cs_n_in,
  input  wire logic                ras_n_in,
  input  wire logic                cas_n_in,
  input  wire logic                we_n_in,
  input  wire logic [2:0]          ba_in,
  input  wire logic [ADDR_W-1:0]   addr_in,
  // Local control
  input  wire logic                viol_clr,
  // Mode and status
  output logic [1:0]               termination_sel,
  output logic                     drive_reduced,
  output dtr_pkg::dtr_drv_t        ocd_drive,
  output logic                     dqs_complement_en,
  output logic                     slow_powerdown_exit,
  output logic [2:0]               additive_latency,
  output dtr_pkg::dtr_pd_t         powerdown_state,
  output logic                     read_ready,
  output logic [3:0]               timing_violation
);

  if (ADDR_W < 13) begin : g_addr_chk
    $error("ADDR_W must reach the power-down exit bit");
  end
  if ((1 << WAIT_W) <= `DTR_XSRD_NCK) begin : g_wait_chk
    $error("WAIT_W too narrow for the self-refresh read wait");
  end

  localparam int UPD_CYC = `DTR_MODE_UPD_CYC;

  typedef struct packed {
    logic                ck_s1, ck_s2, ck_s3;
    logic                cke_s1, cke_s2;
    logic [3:0]          cmd_s1, cmd_s2;
    logic [2:0]          ba_s1, ba_s2;
    logic [ADDR_W-1:0]   a_s1, a_s2;
    logic                cke_prev;
    dtr_pkg::dtr_pd_t    pd;
    logic [7:0]          bank_open;
    logic [WAIT_W-1:0]   read_wait;
    logic                rdy;
    logic [1:0]          gap_col, gap_mrs, gap_cke;
    logic                slow_exit;
    logic [2:0]          al;
    logic [1:0]          rtt;
    logic                ds;
    logic                dqs_diff;
    dtr_pkg::dtr_drv_t   off_chip_drive_calibration;
    logic [1:0]          p_rtt;
    logic                p_ds;
    logic                p_dqs;
    dtr_pkg::dtr_drv_t   p_ocd;
    logic [2:0]          p_al;
    logic [1:0]          upd_cnt;
    logic [3:0]          viol;
  } dtr_state_t;

  dtr_state_t s_r, s_nxt;

  // Command code is {cs_n, ras_n, cas_n, we_n}.
  function automatic logic is_cmd(input logic [3:0] c, input logic [2:0] rcw);
    return (c[3] == 1'b0) && (c[2:0] == rcw);
  endfunction

  function automatic logic [1:0] sat_inc(input logic [1:0] g);
    return (g == 2'h3) ? g : g + 2'h1;
  endfunction

  logic ck_edge, cmd_ok, cmd_rd, cmd_wr, cmd_act, cmd_pre, cmd_ref, cmd_mode, extended_mode_register_set_cmd_hit, mrs_hit;
  logic upd_apply, apd_exit;
  logic [2:0] ocd_field;

  assign ck_edge   = s_r.ck_s2 & ~s_r.ck_s3;
  assign cmd_ok    = ck_edge & s_r.cke_prev & s_r.cke_s2;
  assign cmd_rd    = cmd_ok & is_cmd(s_r.cmd_s2, 3'h5);
  assign cmd_wr    = cmd_ok & is_cmd(s_r.cmd_s2, 3'h4);
  assign cmd_act   = cmd_ok & is_cmd(s_r.cmd_s2, 3'h3);
  assign cmd_pre   = cmd_ok & is_cmd(s_r.cmd_s2, 3'h2);
  assign cmd_ref   = is_cmd(s_r.cmd_s2, 3'h1);
  assign cmd_mode  = cmd_ok & is_cmd(s_r.cmd_s2, 3'h0);
  assign mrs_hit   = cmd_mode & (s_r.ba_s2 == `DTR_BA_MR);
  assign extended_mode_register_set_cmd_hit  = cmd_mode & (s_r.ba_s2 == `DTR_BA_EMR1);
  assign upd_apply = (s_r.upd_cnt == 2'h1);
  assign apd_exit  = ck_edge & ~s_r.cke_prev & s_r.cke_s2 & (s_r.pd == dtr_pkg::PD_ACTIVE);
  assign ocd_field = s_r.a_s2[`DTR_A_OCD_LO +: 3];

  always_comb begin
    logic [1:0]        g;
    logic [WAIT_W-1:0] w;
    logic [WAIT_W-1:0] slow_w;
    s_nxt  = s_r;
    g      = 2'h0;
    w      = '0;
    slow_w = (s_r.al >= 3'h7) ? WAIT_W'(1) : WAIT_W'(`DTR_XARDS_BASE_NCK) - WAIT_W'(s_r.al);
    // Pins and the link clock pass two flops before any decode looks at them.
    s_nxt.ck_s1  = ck_in;
    s_nxt.ck_s2  = s_r.ck_s1;
    s_nxt.ck_s3  = s_r.ck_s2;
    s_nxt.cke_s1 = cke_in;
    s_nxt.cke_s2 = s_r.cke_s1;
    s_nxt.cmd_s1 = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    s_nxt.cmd_s2 = s_r.cmd_s1;
    s_nxt.ba_s1  = ba_in;
    s_nxt.ba_s2  = s_r.ba_s1;
    s_nxt.a_s1   = addr_in;
    s_nxt.a_s2   = s_r.a_s1;
    if (viol_clr) begin
      s_nxt.viol = 4'h0;
    end
    if (ck_edge) begin
      s_nxt.cke_prev = s_r.cke_s2;
      g = sat_inc(s_r.gap_col);
      if ((cmd_rd | cmd_wr) && (g < 2'(`DTR_CCD_NCK))) begin
        s_nxt.viol[0] = 1'b1;
      end
      s_nxt.gap_col = (cmd_rd | cmd_wr) ? 2'h0 : g;
      g = sat_inc(s_r.gap_mrs);
      if (cmd_ok && !is_cmd(s_r.cmd_s2, 3'h7) && (g < 2'(`DTR_MRD_NCK))) begin
        s_nxt.viol[1] = 1'b1;
      end
      s_nxt.gap_mrs = cmd_mode ? 2'h0 : g;
      g = sat_inc(s_r.gap_cke);
      if (s_r.cke_s2 != s_r.cke_prev) begin
        if (g < 2'(`DTR_CKE_NCK)) begin
          s_nxt.viol[2] = 1'b1;
        end
        s_nxt.gap_cke = 2'h0;
      end else begin
        s_nxt.gap_cke = g;
      end
      w = (s_r.read_wait != '0) ? s_r.read_wait - WAIT_W'(1) : '0;
      if (cmd_rd && (w != '0)) begin
        s_nxt.viol[3] = 1'b1;
      end
      s_nxt.read_wait = w;
      if (cmd_act) begin
        s_nxt.bank_open[s_r.ba_s2] = 1'b1;
      end
      if (cmd_pre) begin
        if (s_r.a_s2[`DTR_A_AP]) begin
          s_nxt.bank_open = 8'h00;
        end else begin
          s_nxt.bank_open[s_r.ba_s2] = 1'b0;
        end
      end
      case (s_r.pd)
        dtr_pkg::PD_RUN: begin
          if (s_r.cke_prev && !s_r.cke_s2) begin
            if (cmd_ref) begin
              s_nxt.pd = dtr_pkg::PD_SELF;
            end else if (s_r.bank_open != 8'h00) begin
              s_nxt.pd = dtr_pkg::PD_ACTIVE;
            end else begin
              s_nxt.pd = dtr_pkg::PD_PRECH;
            end
          end
        end
        dtr_pkg::PD_ACTIVE: begin
          if (s_r.cke_s2) begin
            s_nxt.pd        = dtr_pkg::PD_RUN;
            s_nxt.read_wait = s_r.slow_exit ? slow_w : WAIT_W'(`DTR_XARD_NCK);
          end
        end
        dtr_pkg::PD_PRECH: begin
          if (s_r.cke_s2) begin
            s_nxt.pd        = dtr_pkg::PD_RUN;
            s_nxt.read_wait = WAIT_W'(`DTR_XP_NCK);
          end
        end
        dtr_pkg::PD_SELF: begin
          if (s_r.cke_s2) begin
            s_nxt.pd        = dtr_pkg::PD_RUN;
            s_nxt.read_wait = WAIT_W'(`DTR_XSRD_NCK);
          end
        end
        default: begin
          s_nxt.pd = dtr_pkg::PD_RUN;
        end
      endcase
    end
    if (mrs_hit) begin
      s_nxt.slow_exit = s_r.a_s2[`DTR_A_PD_EXIT];
    end
    // Extended settings wait in a pending copy so that they all land on one edge.
    if (s_r.upd_cnt != 2'h0) begin
      s_nxt.upd_cnt = s_r.upd_cnt - 2'h1;
    end
    if (upd_apply) begin
      s_nxt.rtt      = s_r.p_rtt;
      s_nxt.ds       = s_r.p_ds;
      s_nxt.dqs_diff = s_r.p_dqs;
      s_nxt.off_chip_drive_calibration      = s_r.p_ocd;
      s_nxt.al       = s_r.p_al;
    end
    if (extended_mode_register_set_cmd_hit) begin
      s_nxt.p_rtt   = {s_r.a_s2[`DTR_A_RTT1], s_r.a_s2[`DTR_A_RTT0]};
      s_nxt.p_ds    = s_r.a_s2[`DTR_A_DS];
      s_nxt.p_dqs   = ~s_r.a_s2[`DTR_A_DQS_DIS];
      s_nxt.p_al    = s_r.a_s2[`DTR_A_AL_LO +: 3];
      s_nxt.upd_cnt = 2'(UPD_CYC);
      case (ocd_field)
        `DTR_OCD_DRV1: s_nxt.p_ocd = dtr_pkg::DRV_HIGH;
        `DTR_OCD_DRV0: s_nxt.p_ocd = dtr_pkg::DRV_LOW;
        default:       s_nxt.p_ocd = dtr_pkg::DRV_NORMAL;
      endcase
    end
    s_nxt.rdy = (s_nxt.read_wait == '0);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_r           <= '0;
      s_r.pd        <= dtr_pkg::PD_RUN;
      s_r.rdy       <= 1'b1;
      s_r.gap_col   <= 2'h3;
      s_r.gap_mrs   <= 2'h3;
      s_r.gap_cke   <= 2'h3;
      s_r.rtt       <= `DTR_RST_RTT;
      s_r.p_rtt     <= `DTR_RST_RTT;
      s_r.al        <= `DTR_RST_AL;
      s_r.p_al      <= `DTR_RST_AL;
      s_r.dqs_diff  <= `DTR_RST_DQS_DIFF;
      s_r.p_dqs     <= `DTR_RST_DQS_DIFF;
      s_r.off_chip_drive_calibration       <= dtr_pkg::DRV_NORMAL;
      s_r.p_ocd     <= dtr_pkg::DRV_NORMAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign termination_sel     = s_r.rtt;
  assign drive_reduced       = s_r.ds;
  assign ocd_drive           = s_r.off_chip_drive_calibration;
  assign dqs_complement_en   = s_r.dqs_diff;
  assign slow_powerdown_exit = s_r.slow_exit;
  assign additive_latency    = s_r.al;
  assign powerdown_state     = s_r.pd;
  assign read_ready          = s_r.rdy;
  assign timing_violation    = s_r.viol;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_apd_exit_fast;
    apd_exit && !s_r.slow_exit;
  endsequence

  sequence s_apd_exit_slow;
    apd_exit && s_r.slow_exit && (s_r.al < 3'h7);
  endsequence

  property p_mode_upd;
    extended_mode_register_set_cmd_hit ##1 !extended_mode_register_set_cmd_hit |-> ##UPD_CYC (s_r.rtt == $past(s_r.p_rtt, UPD_CYC));
  endproperty
  a_mode_upd: assert property (p_mode_upd) else $error("termination setting late");

  property p_ocd_drive;
    extended_mode_register_set_cmd_hit && (ocd_field == `DTR_OCD_DRV1) ##1 !extended_mode_register_set_cmd_hit |-> ##UPD_CYC (s_r.off_chip_drive_calibration == dtr_pkg::DRV_HIGH);
  endproperty
  a_ocd_drive: assert property (p_ocd_drive) else $error("calibration drive late");

  property p_dqs_sel;
    !$stable(s_r.dqs_diff) |-> $past(upd_apply) && (s_r.dqs_diff == $past(s_r.p_dqs));
  endproperty
  a_dqs_sel: assert property (p_dqs_sel) else $error("strobe mode changed without mode command");

  property p_fast_exit;
    s_apd_exit_fast |=> (s_r.read_wait == WAIT_W'(`DTR_XARD_NCK)) && !read_ready;
  endproperty
  a_fast_exit: assert property (p_fast_exit) else $error("fast exit wait wrong");

  property p_slow_exit;
    s_apd_exit_slow |=> (s_r.read_wait == WAIT_W'(`DTR_XARDS_BASE_NCK) - WAIT_W'(s_r.al));
  endproperty
  a_slow_exit: assert property (p_slow_exit) else $error("slow exit wait wrong");

  property p_mrs_exit_bit;
    mrs_hit |=> (s_r.slow_exit == $past(s_r.a_s2[`DTR_A_PD_EXIT]));
  endproperty
  a_mrs_exit_bit: assert property (p_mrs_exit_bit) else $error("exit mode bit not taken");

endmodule

// >>> bench/dtr_host_model.sv
// Host controller model: makes the link clock and drives clock enable, command and address.
// Assumes clk_sys is the device system clock; one link clock lasts eight system clocks.
`timescale 1ns/1ps

module dtr_host_model (
  // System
  input  wire logic        clk_sys,
  // Link pins
  output logic             ck_in,
  output logic             cke_in,
  output logic [3:0]       cmd_n,
  output logic [2:0]       ba_in,
  output logic [13:0]      addr_in
);
  logic [1:0]  phase_r;
  logic        cke_q;
  logic [3:0]  cmd_q;
  logic [2:0]  ba_q;
  logic [13:0] addr_q;

  initial begin
    ck_in = 1'b0;
    phase_r = 2'h0;
    cke_q = 1'b1;
    cmd_q = 4'h7;
    ba_q = 3'h0;
    addr_q = 14'h0000;
  end

  // The clock never stops, so a clock enable drop is always followed by running clocks.
  always @(posedge clk_sys) begin
    phase_r <= phase_r + 2'h1;
    if (phase_r == 2'h3) begin
      ck_in <= ~ck_in;
    end
  end

  // Pins change on the falling link edge so they stand still around the rising one.
  always @(negedge ck_in) begin
    cke_in  <= cke_q;
    cmd_n   <= cmd_q;
    ba_in   <= ba_q;
    addr_in <= addr_q;
    cmd_q = 4'h7;
  end

  // One command for one link clock; clock enable keeps its level until the next call.
  // A whole 160 ns link clock per command already covers every nanosecond spacing.
  task automatic cmd(input logic k, input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    cke_q = k;
    cmd_q = c;
    ba_q = b;
    addr_q = a;
    @(negedge ck_in);
    @(posedge ck_in);
  endtask
endmodule

// >>> bench/ddr2_command_timing_rules_test.sv
// Self-checking bench of the command timing block.
// Assumes the host model drives every link pin; checks run on falling system clock edges.
`timescale 1ns/1ps
`include "dtr_cfg.svh"

module ddr2_command_timing_rules_test;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_MRS = 4'h0;

  logic              clk_sys;
  logic              resetn;
  logic              viol_clr;
  logic              ck_in;
  logic              cke_in;
  logic [3:0]        cmd_n;
  logic [2:0]        ba_in;
  logic [13:0]       addr_in;
  logic [1:0]        term_sel;
  logic              drv_red;
  dtr_pkg::dtr_drv_t off_chip_drive_calibration;
  logic              dqs_en;
  logic              slow_x;
  logic [2:0]        al;
  dtr_pkg::dtr_pd_t  pd_st;
  logic              rd_rdy;
  logic [3:0]        viol;
  int                error_cnt;
  int                checked;
  int                cyc;

  dtr_host_model dtr_host_model_i (.clk_sys(clk_sys), .ck_in(ck_in), .cke_in(cke_in), .cmd_n(cmd_n),
    .ba_in(ba_in), .addr_in(addr_in));

  dtr_core dtr_core_i (.clk_sys(clk_sys), .resetn(resetn), .ck_in(ck_in), .cke_in(cke_in),
    .cs_n_in(cmd_n[3]), .ras_n_in(cmd_n[2]), .cas_n_in(cmd_n[1]), .we_n_in(cmd_n[0]), .ba_in(ba_in),
    .addr_in(addr_in), .viol_clr(viol_clr), .termination_sel(term_sel), .drive_reduced(drv_red),
    .ocd_drive(off_chip_drive_calibration), .dqs_complement_en(dqs_en), .slow_powerdown_exit(slow_x), .additive_latency(al),
    .powerdown_state(pd_st), .read_ready(rd_rdy), .timing_violation(viol));

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  // The longest wait is the self refresh exit, some 1600 system clocks; the ceiling leaves ample room.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic h(input logic k, input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    dtr_host_model_i.cmd(k, c, b, a);
  endtask

  task automatic nop(input logic k);
    h(k, C_NOP, 3'h0, 14'h0000);
  endtask

  // Lets the synchronisers and the settings registers land before anything is judged.
  task automatic settle();
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic clr();
    @(posedge clk_sys) viol_clr <= 1'b1;
    @(posedge clk_sys) viol_clr <= 1'b0;
  endtask

  task automatic t_reset();
    @(negedge clk_sys);
    chk("dqs", 4'h1, 4'(dqs_en));
    chk("state", 4'h1, 4'(pd_st));
    chk("ready", 4'h1, 4'(rd_rdy));
    chk("viol", 4'h0, viol);
  endtask

  task automatic t_mode();
    h(1'b1, C_MRS, 3'h1, 14'h04DA);
    repeat (2) nop(1'b1);
    settle();
    chk("term", 4'h2, 4'(term_sel));
    chk("drive", 4'h1, 4'(drv_red));
    chk("al", 4'h3, 4'(al));
    chk("ocd", 4'h1, 4'(off_chip_drive_calibration));
    chk("dqs", 4'h0, 4'(dqs_en));
    h(1'b1, C_MRS, 3'h1, 14'h011C);
    repeat (2) nop(1'b1);
    settle();
    chk("term", 4'h1, 4'(term_sel));
    chk("ocd", 4'h2, 4'(off_chip_drive_calibration));
    chk("dqs", 4'h1, 4'(dqs_en));
    h(1'b1, C_MRS, 3'h0, 14'h1000);
    repeat (2) nop(1'b1);
    h(1'b1, C_MRS, 3'h2, 14'h0000);
    repeat (2) nop(1'b1);
    settle();
    chk("slow", 4'h1, 4'(slow_x));
    chk("viol", 4'h0, viol);
  endtask

  task automatic t_space();
    h(1'b1, C_MRS, 3'h0, 14'h1000);
    h(1'b1, C_MRS, 3'h0, 14'h1000);
    settle();
    chk("viol", 4'h2, viol);
    clr();
    h(1'b1, C_RD, 3'h0, 14'h0000);
    h(1'b1, C_RD, 3'h0, 14'h0000);
    settle();
    chk("viol", 4'h1, viol);
    clr();
    h(1'b1, C_RD, 3'h0, 14'h0000);
    nop(1'b1);
    h(1'b1, C_RD, 3'h0, 14'h0000);
    settle();
    chk("viol", 4'h0, viol);
  endtask

  // Enters a power-down kind, leaves it, and times the read wait in link clocks.
  task automatic pd_cycle(input logic [3:0] pre, input logic [3:0] ent, input logic [3:0] st, input int n,
                          input bit early);
    h(1'b1, pre, 3'h0, 14'h0400);
    nop(1'b1);
    h(1'b0, ent, 3'h0, 14'h0000);
    settle();
    chk("state", st, 4'(pd_st));
    nop(1'b0);
    nop(1'b1);
    h(1'b1, early ? C_RD : C_NOP, 3'h0, 14'h0000);
    repeat (n - 2) nop(1'b1);
    settle();
    chk("ready", 4'h0, 4'(rd_rdy));
    chk("state", 4'h1, 4'(pd_st));
    @(posedge ck_in);
    settle();
    chk("ready", 4'h1, 4'(rd_rdy));
    chk("viol", early ? 4'h8 : 4'h0, viol);
    clr();
  endtask

  task automatic t_fast();
    h(1'b1, C_MRS, 3'h0, 14'h0000);
    repeat (2) nop(1'b1);
    settle();
    chk("slow", 4'h0, 4'(slow_x));
    pd_cycle(C_ACT, C_NOP, 4'h2, `DTR_XARD_NCK, 1'b0);
  endtask

  task automatic t_cke_short();
    nop(1'b0);
    nop(1'b1);
    settle();
    chk("viol", 4'h4, viol);
    clr();
  endtask

  initial begin
    resetn = 1'b0;
    viol_clr = 1'b0;
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_mode();
    t_space();
    pd_cycle(C_ACT, C_NOP, 4'h2, `DTR_XARDS_BASE_NCK - 3, 1'b0);
    pd_cycle(C_PRE, C_NOP, 4'h4, `DTR_XP_NCK, 1'b0);
    pd_cycle(C_PRE, C_REF, 4'h8, `DTR_XSRD_NCK, 1'b1);
    t_fast();
    t_cke_short();
    stop_test();
  end
endmodule
